// [hw/pol_logic.v]
/*
 * Programmable output logic array of a supply sequencer: sum-of-products
 * dependency evaluation, per-output timeouts, manual reset, margin
 * hold/force override and reference select.
 * Assumes comparator and watchdog flags arrive as synchronous levels;
 * manual reset and margin pins are asynchronous and are synchronised here.
 */
// Functional notes
// - margin: hold bit 0 keeps, 1 forces
// - level bit picks forced low or high
// - reference bit0: internal 0, external 1
// - deassert only after timeout and conditions
// - no selected condition: stays asserted forever
// - active-high asserted high, active-low asserted low
// - positive monitor fault outside thresholds reads 0
// - negative monitor fault on magnitude window
// - per-output timeout from 25us to 1600ms
// - outputs three and six have two products
// - product true only when all selected healthy
// - two products ORed to deassert
// - first dep register: primaries and watchdogs
// - second dep register: secondaries and general_input_one-2
// - third register gpi3-4, outputs; next out8
// - manual reset map bit asserts output
// - cleared dependency bit ignores that signal
// - active polarity from active-state register
// - margin wins over manual reset
// - timeout runs again after manual reset release
// - gpi polarity bit: 0 low, 1 high active
`timescale 1ns/1ps
`include "pol_map.vh"
module pol_logic #(
    parameter NOUT        = `POL_NUM_OUT,
    parameter TW          = `POL_TMO_W,
    parameter TMO_MIN_CYC = ((`POL_TMO_MIN_NS * (`POL_CLK_HZ / 1000000))
                             + 999) / 1000,
    parameter TMO_MAX_CYC = `POL_TMO_MAX_MS * (`POL_CLK_HZ / 1000)
) (
    input  wire                          clk,
    input  wire                          rst,
    input  wire [7:0]                    cfg_addr,
    input  wire [7:0]                    cfg_wdata,
    input  wire                          cfg_we,
    output wire [7:0]                    cfg_rdata,
    input  wire                          manual_reset_n,
    input  wire                          margin_n,
    input  wire [5:0]                    mon_short_pri,
    input  wire [5:0]                    mon_short_sec,
    input  wire [5:0]                    mon_beyond_sec,
    input  wire [5:0]                    sec_mode_uv,
    input  wire [1:0]                    wdog_expired,
    input  wire [3:0]                    general_input,
    input  wire [(`POL_NUM_TERM-1)*`POL_TERM_W-1:0] ext_term_mask,
    input  wire [NOUT*TW-1:0]            tmo_cycles,
    output wire [NOUT-1:0]               prog_output,
    output wire [NOUT-1:0]               output_asserted,
    output wire                          ext_reference_sel,
    output wire                          margin_active
);
    localparam [TW-1:0] MIN_P = TMO_MIN_CYC[TW-1:0];
    localparam [TW-1:0] MAX_P = TMO_MAX_CYC[TW-1:0];
    localparam          TMW   = `POL_TERM_W;

    // configuration registers
    reg [7:0]      dep_pri_wdog_reg;
    reg [7:0]      dep_sec_gpi_reg;
    reg [7:0]      dep_gpi_outs_reg;
    reg [7:0]      dep_out8_stage_reg;
    reg [7:0]      active_state_reg;
    reg [3:0]      gpi_polarity_reg;
    reg [7:0]      mr_map_reg;
    reg [7:0]      hold_force_reg;
    reg [7:0]      force_level_reg;
    reg            ref_select_reg;
    reg [7:0]      rdata_reg;
    reg [7:0]      rdata_next;

    // output state
    reg [NOUT-1:0] asserted_reg;
    reg [NOUT-1:0] asserted_next;
    reg [NOUT-1:0] held_reg;
    reg [NOUT-1:0] out_reg;
    reg [NOUT-1:0] out_next;
    reg            margin_q_reg;

    wire [1:0]      sync_levels;
    wire            mr_low;
    wire            margin_act;
    wire            margin_entry;
    wire [5:0]      pri_ok;
    wire [5:0]      sec_ok;
    wire [3:0]      gpi_act;
    wire [NOUT*TMW-1:0]           cond_all;
    wire [`POL_NUM_TERM*TMW-1:0]  mask_all;
    wire [`POL_NUM_TERM-1:0]      term_true;
    wire [`POL_NUM_TERM-1:0]      term_used;
    wire [NOUT-1:0] release_ok;
    wire [NOUT-1:0] any_dep;
    wire [NOUT-1:0] mr_force;
    wire [NOUT-1:0] tmo_done;
    wire [NOUT-1:0] pin_logic;

    // picks the seven other outputs in ascending order, skipping self
    function [6:0] pol_others;
        input [7:0] v;
        input integer k;
        integer i;
        integer j;
        begin
            j = 0;
            pol_others = 7'h00;
            for (i = 0; i < 8; i = i + 1) begin
                if (i != k) begin
                    pol_others[j] = v[i];
                    j = j + 1;
                end
            end
        end
    endfunction

    // pin synchronisers
    // pins idle high, so reset to the idle level to avoid a false event
    pol_sync #(
        .W    (2),
        .IDLE (2'b11)
    ) u_sync (
        .clk      (clk),
        .rst      (rst),
        .async_in ({margin_n, manual_reset_n}),
        .sync_out (sync_levels)
    );

    assign mr_low       = ~sync_levels[0];
    assign margin_act   = ~sync_levels[1];
    assign margin_entry = margin_act & ~margin_q_reg;

    // register writes
    always @(posedge clk) begin
        if (rst) begin
            dep_pri_wdog_reg   <= `POL_RST_BYTE;
            dep_sec_gpi_reg    <= `POL_RST_BYTE;
            dep_gpi_outs_reg   <= `POL_RST_BYTE;
            dep_out8_stage_reg <= `POL_RST_BYTE;
            active_state_reg   <= `POL_RST_BYTE;
            gpi_polarity_reg   <= 4'h0;
            mr_map_reg         <= `POL_RST_BYTE;
            hold_force_reg     <= `POL_RST_BYTE;
            force_level_reg    <= `POL_RST_BYTE;
            ref_select_reg     <= 1'b0;
        end else if (cfg_we) begin
            if (cfg_addr == `POL_OFS_DEP_PRI_WDOG) begin
                dep_pri_wdog_reg <= cfg_wdata;
            end else if (cfg_addr == `POL_OFS_DEP_SEC_GPI) begin
                dep_sec_gpi_reg <= cfg_wdata;
            end else if (cfg_addr == `POL_OFS_DEP_GPI_OUTS) begin
                dep_gpi_outs_reg <= cfg_wdata;
            end else if (cfg_addr == `POL_OFS_DEP_OUT8_STAGE) begin
                dep_out8_stage_reg <= cfg_wdata;
            end else if (cfg_addr == `POL_OFS_ACTIVE_STATE) begin
                active_state_reg <= cfg_wdata;
            end else if (cfg_addr == `POL_OFS_GPI_POLARITY) begin
                gpi_polarity_reg <= cfg_wdata[`POL_GPI_POL_MSB:0];
            end else if (cfg_addr == `POL_OFS_MR_MAP) begin
                mr_map_reg <= cfg_wdata;
            end else if (cfg_addr == `POL_OFS_HOLD_FORCE) begin
                hold_force_reg <= cfg_wdata;
            end else if (cfg_addr == `POL_OFS_FORCE_LEVEL) begin
                force_level_reg <= cfg_wdata;
            end else if (cfg_addr == `POL_OFS_REF_SELECT) begin
                ref_select_reg <= cfg_wdata[`POL_BIT_REF_EXT];
            end
        end
    end

    // register read mux, unmapped addresses read zero
    always @* begin
        rdata_next = 8'h00;
        if (cfg_addr == `POL_OFS_DEP_PRI_WDOG) begin
            rdata_next = dep_pri_wdog_reg;
        end else if (cfg_addr == `POL_OFS_DEP_SEC_GPI) begin
            rdata_next = dep_sec_gpi_reg;
        end else if (cfg_addr == `POL_OFS_DEP_GPI_OUTS) begin
            rdata_next = dep_gpi_outs_reg;
        end else if (cfg_addr == `POL_OFS_DEP_OUT8_STAGE) begin
            rdata_next = dep_out8_stage_reg;
        end else if (cfg_addr == `POL_OFS_ACTIVE_STATE) begin
            rdata_next = active_state_reg;
        end else if (cfg_addr == `POL_OFS_GPI_POLARITY) begin
            rdata_next = {4'h0, gpi_polarity_reg};
        end else if (cfg_addr == `POL_OFS_MR_MAP) begin
            rdata_next = mr_map_reg;
        end else if (cfg_addr == `POL_OFS_HOLD_FORCE) begin
            rdata_next = hold_force_reg;
        end else if (cfg_addr == `POL_OFS_FORCE_LEVEL) begin
            rdata_next = force_level_reg;
        end else if (cfg_addr == `POL_OFS_REF_SELECT) begin
            rdata_next = {7'h00, ref_select_reg};
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // bipolar monitor uses the same magnitude flags
    // flags are magnitudes, so one form serves both signs
    assign pri_ok = ~mon_short_pri;
    assign sec_ok = (sec_mode_uv & ~mon_short_sec) |
                    (~sec_mode_uv & ~mon_beyond_sec);

    assign gpi_act = general_input ~^ gpi_polarity_reg;

    assign mask_all[TMW-1:0] = {dep_out8_stage_reg[`POL_BIT_OUT8_SEL],
                                dep_gpi_outs_reg, dep_sec_gpi_reg,
                                dep_pri_wdog_reg};
    assign mask_all[`POL_NUM_TERM*TMW-1:TMW] = ext_term_mask;

    genvar g;
    generate
        for (g = 0; g < NOUT; g = g + 1) begin : g_out
            wire [TW-1:0] per_raw;
            wire [TW-1:0] per_clamp;
            wire          p1_true;
            wire          p1_used;
            wire          p2_true;
            wire          p2_used;

            assign cond_all[g*TMW +: TMW] = {
                ~pol_others(asserted_reg, g),
                ~gpi_act[3:2],
                ~gpi_act[1:0], sec_ok,
                ~wdog_expired, pri_ok};

            assign term_true[g] = &(cond_all[g*TMW +: TMW] |
                                    ~mask_all[g*TMW +: TMW]);
            assign term_used[g] = |mask_all[g*TMW +: TMW];
            assign p1_true      = term_true[g] & term_used[g];
            assign p1_used      = term_used[g];

            // second product only on outputs three and six
            if (g == `POL_OUT3_IDX || g == `POL_OUT6_IDX) begin : g_p2
                localparam T2 = (g == `POL_OUT3_IDX) ?
                                `POL_TERM_OUT3_P2 : `POL_TERM_OUT6_P2;
                assign term_true[T2] = &(cond_all[g*TMW +: TMW] |
                                         ~mask_all[T2*TMW +: TMW]);
                assign term_used[T2] = |mask_all[T2*TMW +: TMW];
                assign p2_true       = term_true[T2] & term_used[T2];
                assign p2_used       = term_used[T2];
            end else begin : g_p1
                assign p2_true = 1'b0;
                assign p2_used = 1'b0;
            end

            assign release_ok[g] = p1_true | p2_true;
            assign any_dep[g]    = p1_used | p2_used;
            assign mr_force[g]   = mr_map_reg[g] & mr_low;

            assign per_raw   = tmo_cycles[g*TW +: TW];
            assign per_clamp = (per_raw < MIN_P) ? MIN_P :
                               (per_raw > MAX_P) ? MAX_P : per_raw;

            // timer restarts after manual reset release
            pol_timer #(
                .W (TW)
            ) u_tmr (
                .clk    (clk),
                .rst    (rst),
                .clear  (~release_ok[g] | ~any_dep[g] | mr_force[g]),
                .hold   (margin_act),
                .period (per_clamp),
                .done   (tmo_done[g])
            );

            assign pin_logic[g] = active_state_reg[g] ? asserted_reg[g]
                                                      : ~asserted_reg[g];
        end

        // unused term slots of absent second products
        for (g = NOUT; g < `POL_NUM_TERM; g = g + 1) begin : g_tie
            if (g != `POL_TERM_OUT3_P2 && g != `POL_TERM_OUT6_P2) begin : g_z
                assign term_true[g] = 1'b0;
                assign term_used[g] = 1'b0;
            end
        end
    endgenerate

    // release only when timed out and satisfied
    // margin freezes state ahead of manual reset
    always @* begin
        asserted_next = asserted_reg;
        if (!margin_act) begin
            asserted_next = mr_force | ~any_dep | ~release_ok |
                            (asserted_reg & ~tmo_done);
        end
    end

    always @* begin
        out_next = pin_logic;
        if (margin_act) begin
            out_next = (hold_force_reg & force_level_reg) |
                       (~hold_force_reg &
                        (margin_q_reg ? held_reg : pin_logic));
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            asserted_reg <= `POL_RST_ASSERTED;
            held_reg     <= 8'h00;
            out_reg      <= 8'h00;
            margin_q_reg <= 1'b0;
        end else begin
            asserted_reg <= asserted_next;
            out_reg      <= out_next;
            margin_q_reg <= margin_act;
            if (margin_entry) begin
                held_reg <= pin_logic;
            end
        end
    end

    assign cfg_rdata         = rdata_reg;
    assign prog_output       = out_reg;
    assign output_asserted   = asserted_reg;
    assign ext_reference_sel = ref_select_reg;
    assign margin_active     = margin_q_reg;
endmodule

// [hw/pol_map.vh]
/*
 * Register offsets, field positions, reset values and timing figures
 * for the programmable output logic array.
 * Assumes an 8-bit configuration port and a 25 MHz system clock.
 */
`ifndef POL_MAP_VH
`define POL_MAP_VH

// register offsets on the configuration port
`define POL_OFS_DEP_PRI_WDOG   8'h0E
`define POL_OFS_DEP_SEC_GPI    8'h0F
`define POL_OFS_DEP_GPI_OUTS   8'h10
`define POL_OFS_DEP_OUT8_STAGE 8'h11
`define POL_OFS_ACTIVE_STATE   8'h3A
`define POL_OFS_GPI_POLARITY   8'h3B
`define POL_OFS_MR_MAP         8'h40
`define POL_OFS_HOLD_FORCE     8'h41
`define POL_OFS_FORCE_LEVEL    8'h42
`define POL_OFS_REF_SELECT     8'h44

// reset values: no dependencies, outputs active-low, hold in margin
`define POL_RST_BYTE           8'h00
`define POL_RST_ASSERTED       8'hFF

// field positions
`define POL_BIT_OUT8_SEL       0
`define POL_BIT_REF_EXT        0
`define POL_GPI_POL_MSB        3

// dependency term layout: 25 condition bits per product
`define POL_TERM_W             25
`define POL_NUM_OUT            8
`define POL_NUM_TERM           10
`define POL_TERM_OUT3_P2       8
`define POL_TERM_OUT6_P2       9
`define POL_OUT3_IDX           2
`define POL_OUT6_IDX           5

// timing
`define POL_CLK_HZ             25000000
`define POL_TMO_MIN_NS         25000
`define POL_TMO_MAX_MS         1600
`define POL_TMO_W              26

`endif

// [hw/pol_sync.v]
/*
 * Two-flop synchroniser for asynchronous level inputs.
 * Assumes the inputs are slow levels; reset value is the idle level.
 */
`timescale 1ns/1ps
module pol_sync #(
    parameter          W        = 2,
    parameter [W-1:0]  IDLE     = {W{1'b1}}
) (
    input  wire         clk,
    input  wire         rst,
    input  wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);
    reg [W-1:0] meta_reg;
    reg [W-1:0] sync_reg;

    // first stage feeds only the second stage
    always @(posedge clk) begin
        if (rst) begin
            meta_reg <= IDLE;
            sync_reg <= IDLE;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;
endmodule

// [hw/pol_timer.v]
/*
 * Per-output timeout counter: counts while the release condition
 * holds and flags done once the programmed period has elapsed.
 * Assumes the period is already clamped to the legal range by the caller.
 */
`timescale 1ns/1ps
module pol_timer #(
    parameter W = 26
) (
    input  wire         clk,
    input  wire         rst,
    input  wire         clear,
    input  wire         hold,
    input  wire [W-1:0] period,
    output wire         done
);
    reg [W-1:0] count_reg;

    // saturate at the period so the count never wraps
    always @(posedge clk) begin
        if (rst || clear) begin
            count_reg <= {W{1'b0}};
        end else if (!hold && !done) begin
            count_reg <= count_reg + {{(W-1){1'b0}}, 1'b1};
        end
    end

    assign done = (count_reg >= period);
endmodule

// [testbench/pol_far_model.sv]
/*
 * Far-side model: monitors, watchdogs and logic inputs of the array,
 * all driven from one fault vector.
 * Assumes controls change at the falling clock edge.
 */
`timescale 1ns/1ps
module pol_far_model (
    input  wire [17:0] fault,
    input  wire [3:0]  gpi_pol,
    input  wire        ov_mode,
    output wire [5:0]  mon_short_pri,
    output wire [5:0]  mon_short_sec,
    output wire [5:0]  mon_beyond_sec,
    output wire [5:0]  sec_mode_uv,
    output wire [1:0]  wdog_expired,
    output wire [3:0]  general_input
);
    assign mon_short_pri  = fault[5:0];
    assign wdog_expired   = fault[7:6];
    assign sec_mode_uv    = {6{~ov_mode}};
    // unused reading is inverted so a wrong pick shows
    assign mon_short_sec  = ov_mode ? ~fault[13:8] : fault[13:8];
    assign mon_beyond_sec = ov_mode ? fault[13:8] : ~fault[13:8];
    assign general_input  = fault[17:14] ~^ gpi_pol;
endmodule

// [testbench/pol_logic_checker.sv]
/*
 * Port checker for the output logic array.
 * Assumes one clock domain and a plain byte config port.
 */
`timescale 1ns/1ps
`include "pol_map.vh"
module pol_logic_checker #(
    parameter NOUT = 8
) (
    input wire                  clk,
    input wire                  rst,
    input wire [7:0]            cfg_addr,
    input wire [7:0]            cfg_wdata,
    input wire                  cfg_we,
    input wire [7:0]            cfg_rdata,
    input wire                  manual_reset_n,
    input wire                  margin_n,
    input wire [(`POL_NUM_TERM-1)*`POL_TERM_W-1:0] ext_term_mask,
    input wire [NOUT-1:0]       prog_output,
    input wire [NOUT-1:0]       output_asserted,
    input wire                  ext_reference_sel,
    input wire                  margin_active
);
    reg [7:0] mr_sh_reg;
    reg [7:0] hf_sh_reg;
    reg [7:0] lv_sh_reg;
    reg [7:0] act_sh_reg;
    reg       ref_sh_reg;

    // shadows of the registers the pins depend on
    always @(posedge clk) begin
        if (rst) begin
            mr_sh_reg  <= 8'h00;
            hf_sh_reg  <= 8'h00;
            lv_sh_reg  <= 8'h00;
            act_sh_reg <= 8'h00;
            ref_sh_reg <= 1'b0;
        end else if (cfg_we) begin
            case (cfg_addr)
                8'h3A: act_sh_reg <= cfg_wdata;
                8'h40: mr_sh_reg  <= cfg_wdata;
                8'h41: hf_sh_reg  <= cfg_wdata;
                8'h42: lv_sh_reg  <= cfg_wdata;
                8'h44: ref_sh_reg <= cfg_wdata[0];
                default: ;
            endcase
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence margin_steady;
        margin_active ##1 margin_active;
    endsequence
    sequence margin_idle;
        !margin_active [*3];
    endsequence

    reset_values_a: assert property (
        $fell(rst) |-> output_asserted == 8'hFF && prog_output == 8'h00)
        else $error("outputs wrong after reset");
    pin_polarity_a: assert property (
        margin_idle |->
        prog_output == ($past(output_asserted) ~^ $past(act_sh_reg)))
        else $error("pin polarity wrong");
    margin_force_a: assert property (
        margin_steady |->
        ((prog_output ^ $past(lv_sh_reg)) & $past(hf_sh_reg)) == 8'h00)
        else $error("forced pin level wrong");
    margin_hold_a: assert property (
        margin_steady ##0 ($past(hf_sh_reg) == $past(hf_sh_reg, 2)) |->
        ((prog_output ^ $past(prog_output)) & ~$past(hf_sh_reg)) == 8'h00)
        else $error("held pin moved");
    margin_freeze_a: assert property (
        margin_steady |-> $stable(output_asserted))
        else $error("state moved in margin");
    mr_assert_a: assert property (
        (!manual_reset_n && mr_sh_reg[0] && margin_n) [*5]
        |-> output_asserted[0])
        else $error("manual reset did not assert");
    no_dep_a: assert property (
        (margin_n && ext_term_mask[`POL_TERM_W-1:0] == 25'h0) [*5]
        |-> output_asserted[1])
        else $error("unconditioned output released");
    ref_select_a: assert property (
        $stable(ref_sh_reg) [*3] |-> ext_reference_sel == ref_sh_reg)
        else $error("reference select wrong");
    unmapped_read_a: assert property (
        cfg_addr == 8'h20 ##1 cfg_addr == 8'h20 |-> cfg_rdata == 8'h00)
        else $error("unmapped read nonzero");
endmodule

bind pol_logic pol_logic_checker #(.NOUT(NOUT)) u_pol_chk (
    .clk(clk), .rst(rst), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_we(cfg_we), .cfg_rdata(cfg_rdata),
    .manual_reset_n(manual_reset_n), .margin_n(margin_n),
    .ext_term_mask(ext_term_mask), .prog_output(prog_output),
    .output_asserted(output_asserted),
    .ext_reference_sel(ext_reference_sel), .margin_active(margin_active)
);

// [testbench/tb.sv]
/*
 * Self-checking bench for the output logic array.
 * Assumes a 25 MHz clock and shortened timeouts.
 */
`timescale 1ns/1ps
module tb;
    localparam TMO = 20, TMIN = 4;
    logic         clk = 1'b0;
    logic         rst = 1'b1;
    logic [7:0]   cfg_addr = 8'h00;
    logic [7:0]   cfg_wdata = 8'h00;
    logic         cfg_we = 1'b0;
    logic         manual_reset_n = 1'b1;
    logic         margin_n = 1'b1;
    logic [224:0] ext_term_mask = 225'h0;
    logic [17:0]  fault = 18'h0;
    logic [3:0]   gpi_pol = 4'h0;
    logic         ov_mode = 1'b0;
    wire  [7:0]   cfg_rdata, prog_output, output_asserted;
    wire  [5:0]   pri, ssec, bsec, uvm;
    wire  [1:0]   wdog;
    wire  [3:0]   gpi;
    wire          ref_sel, margin_active;
    integer       n_fail = 0;
    integer       checks_done = 0;
    integer       cycles = 0;

    // output one is set below the floor to exercise the clamp
    pol_logic #(.TMO_MIN_CYC(TMIN), .TMO_MAX_CYC(2000)) i_dut (
        .clk(clk), .rst(rst), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
        .cfg_we(cfg_we), .cfg_rdata(cfg_rdata),
        .manual_reset_n(manual_reset_n), .margin_n(margin_n),
        .mon_short_pri(pri), .mon_short_sec(ssec), .mon_beyond_sec(bsec),
        .sec_mode_uv(uvm), .wdog_expired(wdog), .general_input(gpi),
        .ext_term_mask(ext_term_mask), .tmo_cycles({{7{26'h14}}, 26'h1}),
        .prog_output(prog_output), .output_asserted(output_asserted),
        .ext_reference_sel(ref_sel), .margin_active(margin_active));

    pol_far_model i_far (
        .fault(fault), .gpi_pol(gpi_pol), .ov_mode(ov_mode),
        .mon_short_pri(pri), .mon_short_sec(ssec), .mon_beyond_sec(bsec),
        .sec_mode_uv(uvm), .wdog_expired(wdog), .general_input(gpi));

    // clock and hang limit
    initial begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 30000) begin
            n_fail = n_fail + 1;
            conclude;
        end
    end

    task conclude;
        begin
            if (n_fail == 0 && checks_done > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("wrong value %s expected %0h seen %0h",
                         what, exp, got);
            end
        end
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        begin
            @(negedge clk);
            cfg_addr = a;
            cfg_wdata = d;
            cfg_we = 1'b1;
            @(negedge clk);
            cfg_we = 1'b0;
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        begin
            @(negedge clk);
            cfg_addr = a;
            @(negedge clk);
            chk("read data", exp, cfg_rdata);
        end
    endtask

    task automatic wait_out(input integer i, input logic v,
                            input integer lim, output integer n);
        begin
            n = 0;
            while (output_asserted[i] !== v && n < lim) begin
                @(negedge clk);
                n = n + 1;
            end
        end
    endtask

    task automatic t_regs;
        localparam [87:0] ADDRS = 88'h0E0F10113A3B4041424420;
        localparam [87:0] MASKS = 88'hFFFFFFFFFF0FFFFFFF0100;
        integer k;
        begin
            chk("asserted at reset", 8'hFF, output_asserted);
            chk("pins at reset", 8'h00, prog_output);
            for (k = 0; k < 11; k = k + 1) begin
                rd(ADDRS[87-8*k -: 8], 8'h00);
                wr(ADDRS[87-8*k -: 8], 8'hA5);
                rd(ADDRS[87-8*k -: 8], 8'hA5 & MASKS[87-8*k -: 8]);
                wr(ADDRS[87-8*k -: 8], 8'h00);
            end
            wr(8'h44, 8'h01);
            repeat (3) @(negedge clk);
            chk("reference select", 1, ref_sel);
        end
    endtask

    // one dependency bit, all other conditions faulty
    task automatic dep_case(input integer idx);
        logic [7:0] a;
        integer     n;
        begin
            a = 8'h0E + idx / 8;
            fault = ~(18'h00001 << idx);
            wr(a, 8'h01 << (idx % 8));
            wait_out(0, 1'b0, TMO + 10, n);
            fault = 18'h3FFFF;
            wait_out(0, 1'b1, 6, n);
            chk("asserted on fault", 1, output_asserted[0]);
            fault = ~(18'h00001 << idx);
            wait_out(0, 1'b0, 100, n);
            chk("release cycles", TMIN + 1, n);
            wr(a, 8'h00);
            fault = 18'h0;
        end
    endtask

    task automatic t_deps;
        integer i;
        begin
            for (i = 0; i < 18; i = i + 1)
                dep_case(i);
            ov_mode = 1'b1;
            dep_case(8);
            ov_mode = 1'b0;
            gpi_pol = 4'hF;
            wr(8'h3B, 8'h0F);
            for (i = 14; i < 18; i = i + 1)
                dep_case(i);
            wr(8'h3B, 8'h00);
            gpi_pol = 4'h0;
        end
    endtask

    // product one watches monitor 1, product two monitor 2
    task automatic two_prod(input integer o, input integer a,
                            input integer b);
        integer n;
        begin
            ext_term_mask[a*25 +: 25] = 25'h1;
            ext_term_mask[b*25 +: 25] = 25'h2;
            fault = 18'h00003;
            repeat (TMO + 10) @(negedge clk);
            chk("both products false", 1, output_asserted[o]);
            fault = 18'h00001;
            wait_out(o, 1'b0, TMO + 10, n);
            chk("second product frees", 0, output_asserted[o]);
            fault = 18'h00003;
            wait_out(o, 1'b1, 6, n);
            fault = 18'h00002;
            wait_out(o, 1'b0, TMO + 10, n);
            chk("first product frees", 0, output_asserted[o]);
            ext_term_mask = 225'h0;
            fault = 18'h0;
        end
    endtask

    task automatic t_out_dep;
        integer n;
        begin
            wr(8'h10, 8'h04);
            repeat (TMO + 10) @(negedge clk);
            chk("held by asserted out2", 1, output_asserted[0]);
            ext_term_mask[24:0] = 25'h1;
            wait_out(0, 1'b0, 2 * TMO + 20, n);
            chk("freed after out2", 0, output_asserted[0]);
            wr(8'h10, 8'h00);
            ext_term_mask = 225'h0;
        end
    endtask

    task automatic t_mr_margin;
        integer n;
        begin
            wr(8'h0E, 8'h01);
            wait_out(0, 1'b0, TMO + 10, n);
            wr(8'h40, 8'h01);
            manual_reset_n = 1'b0;
            wait_out(0, 1'b1, 6, n);
            chk("manual reset asserts", 1, output_asserted[0]);
            repeat (10) @(negedge clk);
            manual_reset_n = 1'b1;
            wait_out(0, 1'b0, 100, n);
            chk("hold after release", TMIN + 3, n);
            wr(8'h41, 8'h06);
            wr(8'h42, 8'h02);
            margin_n = 1'b0;
            repeat (5) @(negedge clk);
            chk("margin pins", 8'h03, prog_output);
            manual_reset_n = 1'b0;
            fault = 18'h00001;
            repeat (8) @(negedge clk);
            chk("margin over reset", 8'h03, prog_output);
            chk("state frozen", 0, output_asserted[0]);
            manual_reset_n = 1'b1;
            fault = 18'h0;
            repeat (4) @(negedge clk);
            margin_n = 1'b1;
            repeat (5) @(negedge clk);
            chk("pins after margin", 8'h01, prog_output);
            wr(8'h3A, 8'hFF);
            repeat (3) @(negedge clk);
            chk("active high pins", 8'hFE, prog_output);
        end
    endtask

    // main sequence
    initial begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        t_regs;
        t_deps;
        two_prod(2, 1, 7);
        two_prod(5, 4, 8);
        t_out_dep;
        t_mr_margin;
        conclude;
    end
endmodule
